// ### rtl/ddr_query_pkg.sv
// Constants for the DDR read latency query table and its byte link
package ddr_query_pkg;
    localparam int unsigned TABLE_BYTES  = 44;
    localparam int unsigned OFFSET_WIDTH = 6;
    localparam logic [7:0]  PARAM_ID     = 8'h9a;
    localparam logic [7:0]  PARAM_LENGTH = 8'h2a;
    localparam logic [7:0]  ROW_COUNT    = 8'h05;
    localparam logic [7:0]  ROW_BYTES    = 8'h08;
    localparam logic [7:0]  NOT_SUPPORTED = 8'hff;
    localparam logic [7:0]  OUT_OF_RANGE = 8'hff;
    // Column positions within a data row
    localparam int unsigned COL_FREQ       = 0;
    localparam int unsigned COL_CODE       = 1;
    localparam int unsigned COL_FAST_MODE  = 2;
    localparam int unsigned COL_FAST_DUMMY = 3;
    localparam int unsigned COL_DUAL_MODE  = 4;
    localparam int unsigned COL_DUAL_DUMMY = 5;
    localparam int unsigned COL_QUAD_MODE  = 6;
    localparam int unsigned COL_QUAD_DUMMY = 7;
    localparam int unsigned FIRST_DATA_ROW = 12;
    localparam int unsigned LENGTH_OFFSET  = 1;

    typedef logic [7:0] byte_type;
    typedef logic [OFFSET_WIDTH-1:0] offset_type;
endpackage

// ### rtl/ddr_query_if.sv
// Byte link between the query table and the host that reads it
`timescale 1ns/1ps
`default_nettype none
interface ddr_query_if;
    import ddr_query_pkg::*;
    logic       req_valid;
    logic       req_write;
    offset_type req_offset;
    byte_type   req_wdata;
    logic       rsp_valid;
    byte_type   rsp_data;

    modport device (
        input  req_valid, req_write, req_offset, req_wdata,
        output rsp_valid, rsp_data
    );
    modport host (
        output req_valid, req_write, req_offset, req_wdata,
        input  rsp_valid, rsp_data
    );
endinterface
`default_nettype wire

// ### rtl/ddr_query_table.sv
// Device end: constant DDR latency query table answering byte reads
`timescale 1ns/1ps
`default_nettype none
module ddr_query_table (
    // Clock and reset
    input  wire logic   sys_clk,
    input  wire logic   reset,
    // Link to host
    ddr_query_if.device link
);
    import ddr_query_pkg::*;

    logic     rsp_valid;
    logic     next_rsp_valid;
    byte_type rsp_data;
    byte_type next_rsp_data;

    // Whole image is a constant ROM; writes never reach it
    localparam byte_type ROM_IMAGE [TABLE_BYTES] = '{
        // Identifier, length, row count, row size
        PARAM_ID, PARAM_LENGTH, ROW_COUNT, ROW_BYTES,
        // Header: F, C, fast, dual, quad codes
        8'h46, 8'h43, 8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee,
        // Row two: 50 MHz, code 11b
        8'h32, 8'h03, 8'h00, 8'h04, 8'h00, 8'h04, 8'h01, 8'h03,
        // Row three: 66 MHz, code 00b
        8'h42, 8'h00, 8'h00, 8'h05, 8'h00, 8'h06, 8'h01, 8'h06,
        // Row four: 66 MHz, code 01b
        8'h42, 8'h01, 8'h00, 8'h06, 8'h00, 8'h07, 8'h01, 8'h07,
        // Row five: 66 MHz, code 10b
        8'h42, 8'h02, 8'h00, 8'h07, 8'h00, 8'h08, 8'h01, 8'h08
    };

    always_comb begin
        next_rsp_valid = link.req_valid && !link.req_write;
        next_rsp_data  = rsp_data;
        if (link.req_valid && !link.req_write) begin
            if (int'(link.req_offset) < TABLE_BYTES) begin
                next_rsp_data = ROM_IMAGE[link.req_offset];
            end else begin
                next_rsp_data = OUT_OF_RANGE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
        end else begin
            rsp_valid <= next_rsp_valid;
            rsp_data  <= next_rsp_data;
        end
    end

    assign link.rsp_valid = rsp_valid;
    assign link.rsp_data  = rsp_data;
endmodule
`default_nettype wire

// ### rtl/ddr_query_reader.sv
// Host end: walks the table and looks up DDR read cycles for a code
`timescale 1ns/1ps
`default_nettype none
module ddr_query_reader (
    // Clock and reset
    input  wire logic   sys_clk,
    input  wire logic   reset,
    // User request
    input  wire logic   start,
    input  wire logic [1:0] latency_code,
    input  wire logic [1:0] command_kind,
    // User result
    output logic        done,
    output logic        found,
    output logic        supported,
    output logic [7:0]  freq_mhz,
    output logic [7:0]  mode_cycles,
    output logic [7:0]  dummy_cycles,
    output logic [7:0]  next_param_offset,
    // Link to device
    ddr_query_if.host   link
);
    import ddr_query_pkg::*;

    typedef enum logic [3:0] {
        IDLE  = 4'b0001,
        ISSUE = 4'b0010,
        WAIT  = 4'b0100,
        STORE = 4'b1000
    } state_type;

    // Walk control
    state_type  state;
    state_type  next_state;
    offset_type offset;
    offset_type next_offset;
    logic       req_valid;
    logic       next_req_valid;
    // Request captured at start, so the inputs may move mid-walk
    logic [1:0] want_code;
    logic [1:0] next_want_code;
    logic [1:0] want_kind;
    logic [1:0] next_want_kind;
    // Row being gathered, one byte per answer
    byte_type   row [ROW_BYTES];
    byte_type   next_row [ROW_BYTES];
    // Next values of the registered outputs
    logic       next_done;
    logic       next_found;
    logic       next_supported;
    byte_type   next_freq;
    byte_type   next_mode;
    byte_type   next_dummy;
    byte_type   next_param_at;
    // Decodes shared by the groups
    logic       begin_walk;
    logic       answer;
    logic       length_byte;
    logic       store;
    offset_type row_pos;
    logic [2:0] col;
    logic [2:0] mode_col;
    logic [2:0] dummy_col;
    logic       row_end;
    logic       last_byte;
    logic       row_match;
    logic       kind_ok;

    ////////////////////////////////////////////////////////////////////////
    assign begin_walk  = (state == IDLE) && start;
    assign answer      = (state == WAIT) && link.rsp_valid;
    assign length_byte = offset == offset_type'(LENGTH_OFFSET);
    assign store       = answer && !length_byte;
    // Column within the current row; data rows are eight bytes long
    assign row_pos     = offset - offset_type'(FIRST_DATA_ROW);
    assign col         = row_pos[2:0];
    assign mode_col    = 3'(COL_FAST_MODE) + {want_kind, 1'b0};
    assign dummy_col   = mode_col + 3'h1;
    assign row_end     = col == 3'(COL_QUAD_DUMMY);
    assign last_byte   = offset == offset_type'(TABLE_BYTES - 1);
    assign row_match   = row[COL_CODE][1:0] == want_code;
    // Kind 3 names no column; it is reported as unsupported
    assign kind_ok     = want_kind != 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Walk: one request per byte, then wait for its answer
    always_comb begin
        next_state     = state;
        next_offset    = offset;
        next_req_valid = 1'b0;
        unique case (state)
            IDLE: begin
                if (start) begin
                    next_offset = offset_type'(LENGTH_OFFSET);
                    next_state  = ISSUE;
                end
            end
            ISSUE: begin
                next_req_valid = 1'b1;
                next_state     = WAIT;
            end
            WAIT: begin
                // Length byte is not part of a row; go on to the first data row, past the header
                if (link.rsp_valid && length_byte) begin
                    next_offset = offset_type'(FIRST_DATA_ROW);
                    next_state  = ISSUE;
                end else if (link.rsp_valid) begin
                    next_state = STORE;
                end
            end
            STORE: begin
                // Ascending offsets up to the last table byte
                next_offset = offset + 6'h01;
                if (last_byte) begin
                    next_state = IDLE;
                end else begin
                    next_state = ISSUE;
                end
            end
            default: next_state = IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state     <= IDLE;
            offset    <= '0;
            req_valid <= 1'b0;
        end else begin
            state     <= next_state;
            offset    <= next_offset;
            req_valid <= next_req_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_want_code = want_code;
        next_want_kind = want_kind;
        if (begin_walk) begin
            next_want_code = latency_code;
            next_want_kind = command_kind;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            want_code <= 2'h0;
            want_kind <= 2'h0;
        end else begin
            want_code <= next_want_code;
            want_kind <= next_want_kind;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Each row byte lands in its own column as it is answered
    for (genvar i = 0; i < ROW_BYTES; i++) begin : g_row
        assign next_row[i] = (store && col == 3'(i)) ? link.rsp_data
                                                     : row[i];
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            row <= '{default: 8'h00};
        end else begin
            row <= next_row;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Results; the last matching row wins, as the codes are unique
    always_comb begin
        next_done      = 1'b0;
        next_found     = found;
        next_supported = supported;
        next_freq      = freq_mhz;
        next_mode      = mode_cycles;
        next_dummy     = dummy_cycles;
        next_param_at  = next_param_offset;
        if (begin_walk) begin
            next_found     = 1'b0;
            next_supported = 1'b0;
        end
        if (answer && length_byte) begin
            // Next parameter: length plus its own offset plus one
            next_param_at = link.rsp_data + 8'(LENGTH_OFFSET + 1);
        end
        if (state == STORE && row_end) begin
            if (row_match) begin
                next_found     = 1'b1;
                next_freq      = row[COL_FREQ];
                next_mode      = kind_ok ? row[mode_col] : NOT_SUPPORTED;
                next_dummy     = kind_ok ? row[dummy_col] : NOT_SUPPORTED;
                // All-ones count marks an unsupported command
                next_supported = kind_ok &&
                                 (row[mode_col] != NOT_SUPPORTED) &&
                                 (row[dummy_col] != NOT_SUPPORTED);
            end
            next_done = last_byte;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            done              <= 1'b0;
            found             <= 1'b0;
            supported         <= 1'b0;
            freq_mhz          <= 8'h00;
            mode_cycles       <= 8'h00;
            dummy_cycles      <= 8'h00;
            next_param_offset <= 8'h00;
        end else begin
            done              <= next_done;
            found             <= next_found;
            supported         <= next_supported;
            freq_mhz          <= next_freq;
            mode_cycles       <= next_mode;
            dummy_cycles      <= next_dummy;
            next_param_offset <= next_param_at;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host only reads; the table is never written
    assign link.req_valid  = req_valid;
    assign link.req_write  = 1'b0;
    assign link.req_offset = offset;
    assign link.req_wdata  = 8'h00;
endmodule
`default_nettype wire

// ### test/ddr_query_asserts.sv
// Checker for the byte link between the reader and the table
`timescale 1ns/1ps
`default_nettype none
module ddr_query_asserts (
    // Clock and reset
    input wire logic                      sys_clk,
    input wire logic                      reset,
    // Link signals
    input wire logic                      req_valid,
    input wire logic                      req_write,
    input wire ddr_query_pkg::offset_type req_offset,
    input wire logic                      rsp_valid,
    input wire ddr_query_pkg::byte_type   rsp_data
);
    import ddr_query_pkg::*;
    wire logic rd = req_valid && !req_write;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    chk_length_byte: assert property (
        rd && req_offset == 6'h01 |=> rsp_valid && rsp_data == 8'h2a)
        else $error("length byte wrong");
    chk_row2_freq: assert property (
        rd && req_offset == 6'h0c |=> rsp_valid && rsp_data == 8'h32)
        else $error("row two frequency wrong");
    chk_row2_quad: assert property (
        rd && req_offset == 6'h13 |=> rsp_data == 8'h03)
        else $error("row two quad dummy wrong");
    chk_row3_freq: assert property (
        rd && req_offset == 6'h14 |=> rsp_data == 8'h42)
        else $error("row three frequency wrong");
    chk_row3_dual: assert property (
        rd && req_offset == 6'h19 |=> rsp_data == 8'h06)
        else $error("row three dual dummy wrong");
    chk_row4_freq: assert property (
        rd && req_offset == 6'h1c |=> rsp_data == 8'h42)
        else $error("row four frequency wrong");
    chk_row4_quad: assert property (
        rd && req_offset == 6'h23 |=> rsp_data == 8'h07)
        else $error("row four quad dummy wrong");
    chk_row5_dual: assert property (
        rd && req_offset == 6'h29 |=> rsp_data == 8'h08)
        else $error("row five dual dummy wrong");
    chk_answer_cause: assert property (
        rsp_valid |-> $past(rd))
        else $error("answer without a read");
    chk_data_holds: assert property (
        !rsp_valid |-> $stable(rsp_data))
        else $error("byte changed without a read");
endmodule
`default_nettype wire

// ### test/test_ddr_query_table.sv
// Self-checking bench for the query table and its reader
`timescale 1ns/1ps
`default_nettype none
module test_ddr_read_latency_query_table;
    import ddr_query_pkg::*;
    logic       sys_clk      = 1'b0;
    logic       reset        = 1'b1;
    logic       start        = 1'b0;
    logic [1:0] latency_code = 2'h0;
    logic [1:0] command_kind = 2'h0;
    logic       done, found, supported;
    logic [7:0] freq_mhz, mode_cycles, dummy_cycles, next_param_offset;
    int         fails     = 0;
    int         tests_run = 0;
    int         cycles    = 0;
    byte_type   exp_tab [44] = '{
        8'h9a, 8'h2a, 8'h05, 8'h08, 8'h46, 8'h43, 8'h0d, 8'h0e,
        8'hbd, 8'hbe, 8'hed, 8'hee, 8'h32, 8'h03, 8'h00, 8'h04,
        8'h00, 8'h04, 8'h01, 8'h03, 8'h42, 8'h00, 8'h00, 8'h05,
        8'h00, 8'h06, 8'h01, 8'h06, 8'h42, 8'h01, 8'h00, 8'h06,
        8'h00, 8'h07, 8'h01, 8'h07, 8'h42, 8'h02, 8'h00, 8'h07,
        8'h00, 8'h08, 8'h01, 8'h08};
    ddr_query_if link ();
    // Second table driven straight by the bench to reach every table offset and one past it
    ddr_query_if probe ();
    ddr_query_table i_ddr_query_table (.sys_clk(sys_clk), .reset(reset),
        .link(link.device));
    ddr_query_table i_ddr_query_table_b (.sys_clk(sys_clk), .reset(reset),
        .link(probe.device));
    ddr_query_reader i_ddr_query_reader (.sys_clk(sys_clk), .reset(reset),
        .start(start), .latency_code(latency_code),
        .command_kind(command_kind), .done(done), .found(found),
        .supported(supported), .freq_mhz(freq_mhz),
        .mode_cycles(mode_cycles), .dummy_cycles(dummy_cycles),
        .next_param_offset(next_param_offset), .link(link.host));
    ddr_query_asserts i_ddr_query_asserts (.sys_clk(sys_clk),
        .reset(reset), .req_valid(link.req_valid),
        .req_write(link.req_write), .req_offset(link.req_offset),
        .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));
    always #10 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk8(input byte_type got, input byte_type exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic probe_read(input int off);
        @(negedge sys_clk);
        probe.req_valid  = 1'b1;
        probe.req_write  = 1'b0;
        probe.req_offset = off[5:0];
        @(posedge sys_clk);
        #1 chk8({7'h0, probe.rsp_valid}, 8'h01);
        chk8(probe.rsp_data, off < 44 ? exp_tab[off] : 8'hff);
    endtask
    // Back to back through the whole table and one step past it
    task automatic t_walk;
        for (int i = 0; i <= 44; i++)
            probe_read(i);
        @(negedge sys_clk);
        probe.req_valid = 1'b0;
        @(posedge sys_clk);
        #1 chk8({7'h0, probe.rsp_valid}, 8'h00);
        chk8(probe.rsp_data, 8'hff);
    endtask
    task automatic t_write;
        @(negedge sys_clk);
        probe.req_valid = 1'b1;
        probe.req_write = 1'b1;
        probe.req_offset = 6'h00;
        probe.req_wdata = 8'h55;
        @(posedge sys_clk);
        #1 chk8({7'h0, probe.rsp_valid}, 8'h00);
        chk8(probe.rsp_data, 8'hff);
        probe_read(0);
        @(negedge sys_clk);
        probe.req_valid = 1'b0;
    endtask
    task automatic t_lookup(input int code, input int kind);
        int base;
        int n;
        byte_type exp_m;
        byte_type exp_d;
        base = 12 + 8 * ((code + 1) % 4);
        @(negedge sys_clk);
        start = 1'b1;
        latency_code = code[1:0];
        command_kind = kind[1:0];
        @(negedge sys_clk);
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            #1 n++;
        end
        exp_m = kind < 3 ? exp_tab[base + 2 + 2 * kind] : 8'hff;
        exp_d = kind < 3 ? exp_tab[base + 3 + 2 * kind] : 8'hff;
        chk8({7'h0, done}, 8'h01);
        chk8({6'h0, found, supported}, {6'h0, 1'b1, kind < 3});
        chk8(freq_mhz, exp_tab[base]);
        chk8(mode_cycles, exp_m);
        chk8(dummy_cycles, exp_d);
        chk8(next_param_offset, 8'h2c);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        probe.req_valid = 1'b0;
        probe.req_write = 1'b0;
        probe.req_offset = 6'h00;
        probe.req_wdata = 8'h00;
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        t_walk();
        t_write();
        for (int c = 0; c < 4; c++)
            for (int k = 0; k < 4; k++)
                t_lookup(c, k);
        end_sim();
    end
endmodule
`default_nettype wire
